// ### verilog/adcs_defs.vh
// Register offsets, field positions, reset values and counts of the clock select block
`ifndef ADCS_DEFS_VH
`define ADCS_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADCS_OFS_INPUT_PAIR 5'h00
`define ADCS_OFS_GAIN 5'h01
`define ADCS_OFS_RATE 5'h02
`define ADCS_OFS_ANA_A 5'h03
`define ADCS_OFS_ANA_B 5'h04
`define ADCS_OFS_ANA_C 5'h05
`define ADCS_OFS_ANA_D 5'h06
`define ADCS_OFS_ANA_E 5'h07
`define ADCS_OFS_ANA_F 5'h08
`define ADCS_OFS_RES_LO 5'h09
`define ADCS_OFS_RES_MID 5'h0A
`define ADCS_OFS_RES_HI 5'h0B
`define ADCS_OFS_ANA_G 5'h0C
`define ADCS_OFS_SER_FLAG 5'h0E
`define ADCS_OFS_SER_CTRL 5'h0F
`define ADCS_OFS_SER_TMO 5'h10
`define ADCS_OFS_RC_CTRL 5'h11
`define ADCS_OFS_XT_CTRL 5'h12

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ADCS_RST_INPUT_PAIR 8'h00
`define ADCS_RST_GAIN 8'h00
`define ADCS_RST_RATE 8'h01
`define ADCS_RST_ANA_A 8'h01
`define ADCS_RST_ANA_B 8'h26
`define ADCS_RST_ANA_C 8'h20
`define ADCS_RST_ANA_D 8'h07
`define ADCS_RST_ANA_E 8'h01
`define ADCS_RST_ANA_F 8'h14
`define ADCS_RST_ANA_G 8'h01
`define ADCS_RST_SER_FLAG 8'h00
`define ADCS_RST_SER_CTRL 8'h00
`define ADCS_RST_SER_TMO 8'h00
`define ADCS_RST_RC_CTRL 8'h00
`define ADCS_RST_XT_CTRL 8'h00

// ----------------------------------------
// Implemented-bit masks
// ----------------------------------------
`define ADCS_MASK_ANA_G 8'h01
`define ADCS_MASK_SER_FLAG 8'h01
`define ADCS_MASK_SER_CTRL 8'h3E

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ADCS_RC_EN_BIT 0
`define ADCS_RC_FLAG_BIT 1
`define ADCS_RC_OUT_BIT 2
`define ADCS_XT_EN_BIT 0
`define ADCS_XT_FLAG_BIT 1
`define ADCS_XT_MODE_BIT 2
`define ADCS_XT_OUT_BIT 3

// ----------------------------------------
// Counts in oscillator cycles
// ----------------------------------------
`define ADCS_RC_SETTLE 16
`define ADCS_XT_SETTLE 1024
`define ADCS_CLK_DIV 4096

`endif

// ### verilog/adcs_sync.v
// Two-stage synchroniser with rising edge pulse for an oscillator pin
`timescale 1ns/100ps
module adcs_sync (
	clk,
	rst,
	pin_in,
	rise_pulse
);
	input wire clk;
	input wire rst;
	input wire pin_in;
	output wire rise_pulse;

	reg meta_q;
	reg sync_q;
	reg last_q;

	// ----------------------------------------
	// Only the second stage feeds the edge detector
	// ----------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= pin_in;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign rise_pulse = sync_q & ~last_q;
endmodule

// ### verilog/adcs_osc_mon.v
// Oscillator stability counter and divide-by-N clock output
`timescale 1ns/100ps
module adcs_osc_mon #(
	parameter SETTLE = 16,
	parameter DIV = 4096,
	parameter CW = 16
) (
	clk,
	rst,
	osc_en,
	osc_edge,
	stable,
	div_clk
);
	input wire clk;
	input wire rst;
	input wire osc_en;
	input wire osc_edge;
	output wire stable;
	output wire div_clk;

	localparam integer SETTLE_I = SETTLE;
	localparam integer HALF_I = DIV / 2 - 1;
	localparam [CW-1:0] SETTLE_C = SETTLE_I[CW-1:0];
	localparam [CW-1:0] HALF_C = HALF_I[CW-1:0];

	reg [CW-1:0] settle_q;
	reg stable_q;
	reg [CW-1:0] div_cnt_q;
	reg div_q;

	// ----------------------------------------
	// Stability: cleared while disabled, set after SETTLE edges
	// ----------------------------------------
	always @(posedge clk) begin
		if (rst || !osc_en) begin
			settle_q <= {CW{1'b0}};
			stable_q <= 1'b0;
		end else if (osc_edge && !stable_q) begin
			if (settle_q == SETTLE_C - 1'b1) begin
				stable_q <= 1'b1;
			end
			settle_q <= settle_q + 1'b1;
		end
	end

	// ----------------------------------------
	// Divider: toggles every DIV/2 edges, a full period of DIV edges
	// ----------------------------------------
	always @(posedge clk) begin
		if (rst || !osc_en) begin
			div_cnt_q <= {CW{1'b0}};
			div_q <= 1'b0;
		end else if (osc_edge) begin
			if (div_cnt_q == HALF_C) begin
				div_cnt_q <= {CW{1'b0}};
				div_q <= ~div_q;
			end else begin
				div_cnt_q <= div_cnt_q + 1'b1;
			end
		end
	end

	assign stable = stable_q;
	assign div_clk = div_q;
endmodule

// ### verilog/adcs_top.v
// Register map and oscillator control of the converter clock select block
//
// Contract
// - Host reads all registers serially and writes all but the three result bytes
// - Result held as three bytes, low first
// - Reset loads defaults; both oscillators disabled
// - RC output bit drives RC/4096 on ready
// - RC stable flag set after 16 cycles
// - Crystal output bit drives crystal/4096 on ready while the RC output bit is clear
// - Crystal mode bit selects drive current
// - Mode bit frozen while crystal enabled
// - Crystal stable flag cleared, then set later
// - Unimplemented oscillator control bits read zero
`timescale 1ns/100ps
`include "adcs_defs.vh"
module adcs_top #(
	parameter XT_SETTLE = `ADCS_XT_SETTLE
) (
	clk,
	rst,
	reg_addr,
	reg_wr,
	reg_rd,
	reg_wdata,
	reg_rdata,
	result_data,
	result_valid,
	data_ready_n,
	rc_osc_clk,
	xtal_osc_clk,
	data_ready_n_pin,
	rc_osc_enable,
	xtal_osc_enable,
	xtal_drive_mode,
	input_pair_select,
	amplifier_gain_select,
	output_rate_config,
	analog_config_a,
	analog_config_b,
	analog_config_c,
	analog_config_d,
	analog_config_e,
	analog_config_f,
	analog_config_g,
	serial_iface_flag,
	serial_iface_control,
	serial_timeout_control
);
	input wire clk;
	input wire rst;
	input wire [4:0] reg_addr;
	input wire reg_wr;
	input wire reg_rd;
	input wire [7:0] reg_wdata;
	output wire [7:0] reg_rdata;
	input wire [23:0] result_data;
	input wire result_valid;
	input wire data_ready_n;
	input wire rc_osc_clk;
	input wire xtal_osc_clk;
	output wire data_ready_n_pin;
	output wire rc_osc_enable;
	output wire xtal_osc_enable;
	output wire xtal_drive_mode;
	output wire [7:0] input_pair_select;
	output wire [7:0] amplifier_gain_select;
	output wire [7:0] output_rate_config;
	output wire [7:0] analog_config_a;
	output wire [7:0] analog_config_b;
	output wire [7:0] analog_config_c;
	output wire [7:0] analog_config_d;
	output wire [7:0] analog_config_e;
	output wire [7:0] analog_config_f;
	output wire [7:0] analog_config_g;
	output wire [7:0] serial_iface_flag;
	output wire [7:0] serial_iface_control;
	output wire [7:0] serial_timeout_control;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	reg [7:0] pair_q;
	reg [7:0] gain_q;
	reg [7:0] rate_q;
	reg [7:0] ana_a_q;
	reg [7:0] ana_b_q;
	reg [7:0] ana_c_q;
	reg [7:0] ana_d_q;
	reg [7:0] ana_e_q;
	reg [7:0] ana_f_q;
	reg [7:0] ana_g_q;
	reg [7:0] ser_flag_q;
	reg [7:0] ser_ctrl_q;
	reg [7:0] ser_tmo_q;
	reg [23:0] result_q;
	reg rc_en_q;
	reg rc_out_q;
	reg xt_en_q;
	reg xt_mode_q;
	reg xt_out_q;
	reg [7:0] rdata_q;
	reg [7:0] rdata_d;
	reg drdy_q;
	reg drdy_d;
	wire rc_edge;
	wire xt_edge;
	wire rc_stable;
	wire xt_stable;
	wire rc_div;
	wire xt_div;
	function wr_hit;
		input [4:0] addr;
		input [4:0] ofs;
		input wr;
		begin
			wr_hit = wr && (addr == ofs);
		end
	endfunction

	// ----------------------------------------
	// Oscillator pins into the register clock domain
	// ----------------------------------------
	adcs_sync u_rc_sync (
		.clk(clk),
		.rst(rst),
		.pin_in(rc_osc_clk),
		.rise_pulse(rc_edge)
	);
	adcs_sync u_xt_sync (
		.clk(clk),
		.rst(rst),
		.pin_in(xtal_osc_clk),
		.rise_pulse(xt_edge)
	);

	// ----------------------------------------
	// Stability and divided clocks
	// ----------------------------------------
	adcs_osc_mon #(
		.SETTLE(`ADCS_RC_SETTLE),
		.DIV(`ADCS_CLK_DIV),
		.CW(16)
	) u_rc_mon (
		.clk(clk),
		.rst(rst),
		.osc_en(rc_en_q),
		.osc_edge(rc_edge),
		.stable(rc_stable),
		.div_clk(rc_div)
	);

	// Flag is held low while enable is clear, then rises after settling
	adcs_osc_mon #(
		.SETTLE(XT_SETTLE),
		.DIV(`ADCS_CLK_DIV),
		.CW(16)
	) u_xt_mon (
		.clk(clk),
		.rst(rst),
		.osc_en(xt_en_q),
		.osc_edge(xt_edge),
		.stable(xt_stable),
		.div_clk(xt_div)
	);

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			pair_q <= `ADCS_RST_INPUT_PAIR;
			gain_q <= `ADCS_RST_GAIN;
			rate_q <= `ADCS_RST_RATE;
			ana_a_q <= `ADCS_RST_ANA_A;
			ana_b_q <= `ADCS_RST_ANA_B;
			ana_c_q <= `ADCS_RST_ANA_C;
			ana_d_q <= `ADCS_RST_ANA_D;
			ana_e_q <= `ADCS_RST_ANA_E;
			ana_f_q <= `ADCS_RST_ANA_F;
			ana_g_q <= `ADCS_RST_ANA_G;
			ser_flag_q <= `ADCS_RST_SER_FLAG;
			ser_ctrl_q <= `ADCS_RST_SER_CTRL;
			ser_tmo_q <= `ADCS_RST_SER_TMO;
			rc_en_q <= |(`ADCS_RST_RC_CTRL & (8'h01 << `ADCS_RC_EN_BIT));
			rc_out_q <= |(`ADCS_RST_RC_CTRL & (8'h01 << `ADCS_RC_OUT_BIT));
			xt_en_q <= |(`ADCS_RST_XT_CTRL & (8'h01 << `ADCS_XT_EN_BIT));
			xt_mode_q <= |(`ADCS_RST_XT_CTRL & (8'h01 << `ADCS_XT_MODE_BIT));
			xt_out_q <= |(`ADCS_RST_XT_CTRL & (8'h01 << `ADCS_XT_OUT_BIT));
		end else begin
			if (wr_hit(reg_addr, `ADCS_OFS_INPUT_PAIR, reg_wr)) begin
				pair_q <= reg_wdata;
			end
			if (wr_hit(reg_addr, `ADCS_OFS_GAIN, reg_wr)) begin
				gain_q <= reg_wdata;
			end
			if (wr_hit(reg_addr, `ADCS_OFS_RATE, reg_wr)) begin
				rate_q <= reg_wdata;
			end
			if (wr_hit(reg_addr, `ADCS_OFS_ANA_A, reg_wr)) begin
				ana_a_q <= reg_wdata;
			end
			if (wr_hit(reg_addr, `ADCS_OFS_ANA_B, reg_wr)) begin
				ana_b_q <= reg_wdata;
			end
			if (wr_hit(reg_addr, `ADCS_OFS_ANA_C, reg_wr)) begin
				ana_c_q <= reg_wdata;
			end
			if (wr_hit(reg_addr, `ADCS_OFS_ANA_D, reg_wr)) begin
				ana_d_q <= reg_wdata;
			end
			if (wr_hit(reg_addr, `ADCS_OFS_ANA_E, reg_wr)) begin
				ana_e_q <= reg_wdata;
			end
			if (wr_hit(reg_addr, `ADCS_OFS_ANA_F, reg_wr)) begin
				ana_f_q <= reg_wdata;
			end
			if (wr_hit(reg_addr, `ADCS_OFS_ANA_G, reg_wr)) begin
				ana_g_q <= reg_wdata & `ADCS_MASK_ANA_G;
			end
			if (wr_hit(reg_addr, `ADCS_OFS_SER_FLAG, reg_wr)) begin
				ser_flag_q <= reg_wdata & `ADCS_MASK_SER_FLAG;
			end
			if (wr_hit(reg_addr, `ADCS_OFS_SER_CTRL, reg_wr)) begin
				ser_ctrl_q <= reg_wdata & `ADCS_MASK_SER_CTRL;
			end
			if (wr_hit(reg_addr, `ADCS_OFS_SER_TMO, reg_wr)) begin
				ser_tmo_q <= reg_wdata;
			end
			// Stable flag bit of the written byte is dropped
			if (wr_hit(reg_addr, `ADCS_OFS_RC_CTRL, reg_wr)) begin
				rc_en_q <= reg_wdata[`ADCS_RC_EN_BIT];
				rc_out_q <= reg_wdata[`ADCS_RC_OUT_BIT];
			end
			if (wr_hit(reg_addr, `ADCS_OFS_XT_CTRL, reg_wr)) begin
				xt_en_q <= reg_wdata[`ADCS_XT_EN_BIT];
				xt_out_q <= reg_wdata[`ADCS_XT_OUT_BIT];
				// Changing drive while running could stall the crystal
				if (!xt_en_q) begin
					xt_mode_q <= reg_wdata[`ADCS_XT_MODE_BIT];
				end
			end
		end
	end

	// ----------------------------------------
	// Conversion result capture
	// ----------------------------------------
	// Cleared at reset only so reads are never X; software must not rely on it
	always @(posedge clk) begin
		if (rst) begin
			result_q <= 24'h000000;
		end else if (result_valid) begin
			result_q <= result_data;
		end
	end

	// ----------------------------------------
	// Register reads, answered one cycle after reg_rd
	// ----------------------------------------
	always @* begin
		rdata_d = 8'h00;
		case (reg_addr)
			`ADCS_OFS_INPUT_PAIR: rdata_d = pair_q;
			`ADCS_OFS_GAIN: rdata_d = gain_q;
			`ADCS_OFS_RATE: rdata_d = rate_q;
			`ADCS_OFS_ANA_A: rdata_d = ana_a_q;
			`ADCS_OFS_ANA_B: rdata_d = ana_b_q;
			`ADCS_OFS_ANA_C: rdata_d = ana_c_q;
			`ADCS_OFS_ANA_D: rdata_d = ana_d_q;
			`ADCS_OFS_ANA_E: rdata_d = ana_e_q;
			`ADCS_OFS_ANA_F: rdata_d = ana_f_q;
			`ADCS_OFS_RES_LO: rdata_d = result_q[7:0];
			`ADCS_OFS_RES_MID: rdata_d = result_q[15:8];
			`ADCS_OFS_RES_HI: rdata_d = result_q[23:16];
			`ADCS_OFS_ANA_G: rdata_d = ana_g_q;
			`ADCS_OFS_SER_FLAG: rdata_d = ser_flag_q;
			`ADCS_OFS_SER_CTRL: rdata_d = ser_ctrl_q;
			`ADCS_OFS_SER_TMO: rdata_d = ser_tmo_q;
			`ADCS_OFS_RC_CTRL: rdata_d = {5'h00, rc_out_q, rc_stable, rc_en_q};
			`ADCS_OFS_XT_CTRL: rdata_d = {4'h0, xt_out_q, xt_mode_q, xt_stable, xt_en_q};
			default: rdata_d = 8'h00;
		endcase
	end

	always @(posedge clk) begin
		if (rst) begin
			rdata_q <= 8'h00;
		end else if (reg_rd) begin
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------
	// Ready pin multiplexer
	// ----------------------------------------
	// RC output wins if software sets both output bits
	always @* begin
		if (rc_out_q) begin
			drdy_d = rc_div;
		end else if (xt_out_q) begin
			drdy_d = xt_div;
		end else begin
			drdy_d = data_ready_n;
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			drdy_q <= 1'b1;
		end else begin
			drdy_q <= drdy_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata = rdata_q;
	assign data_ready_n_pin = drdy_q;
	// Both enables may be high if the host breaks the exclusivity rule; not guarded
	assign rc_osc_enable = rc_en_q;
	assign xtal_osc_enable = xt_en_q;
	assign xtal_drive_mode = xt_mode_q;
	assign input_pair_select = pair_q;
	assign amplifier_gain_select = gain_q;
	assign output_rate_config = rate_q;
	assign analog_config_a = ana_a_q;
	assign analog_config_b = ana_b_q;
	assign analog_config_c = ana_c_q;
	assign analog_config_d = ana_d_q;
	assign analog_config_e = ana_e_q;
	assign analog_config_f = ana_f_q;
	assign analog_config_g = ana_g_q;
	assign serial_iface_flag = ser_flag_q;
	assign serial_iface_control = ser_ctrl_q;
	assign serial_timeout_control = ser_tmo_q;
endmodule

// ### verif/adcs_top_properties.sv
// Concurrent checks on the ports of the clock select block
`timescale 1ns/100ps
`include "adcs_defs.vh"
module adcs_chk (
	input wire clk,
	input wire rst,
	input wire [4:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_wdata,
	input wire [7:0] reg_rdata,
	input wire [23:0] result_data,
	input wire result_valid,
	input wire data_ready_n,
	input wire data_ready_n_pin,
	input wire rc_osc_enable,
	input wire xtal_osc_enable,
	input wire xtal_drive_mode
);
	// ----------------------------------------
	// Shadow of output bits and captured result
	// ----------------------------------------
	reg rc_out_q;
	reg xt_out_q;
	reg [23:0] res_q;
	wire wr_rc = reg_wr && reg_addr == `ADCS_OFS_RC_CTRL;
	wire wr_xt = reg_wr && reg_addr == `ADCS_OFS_XT_CTRL;
	always @(posedge clk) begin
		if (rst) begin
			rc_out_q <= 1'b0;
			xt_out_q <= 1'b0;
			res_q <= 24'h000000;
		end else begin
			if (wr_rc)
				rc_out_q <= reg_wdata[2];
			if (wr_xt)
				xt_out_q <= reg_wdata[3];
			if (result_valid)
				res_q <= result_data;
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_rc_en_write: assert property (
		wr_rc |=> rc_osc_enable == $past(reg_wdata[0])) else $error("rc enable not written");
	a_xt_en_write: assert property (
		wr_xt |=> xtal_osc_enable == $past(reg_wdata[0])) else $error("crystal enable not written");
	a_mode_frozen: assert property (
		xtal_osc_enable |=> $stable(xtal_drive_mode)) else $error("mode changed while enabled");
	a_mode_write: assert property (
		wr_xt && !xtal_osc_enable |=> xtal_drive_mode == $past(reg_wdata[2])) else $error("mode not written");
	a_reset_state: assert property (
		$fell(rst) |-> !rc_osc_enable && !xtal_osc_enable && !xtal_drive_mode && data_ready_n_pin)
		else $error("reset state wrong");
	a_res_low: assert property (
		reg_rd && reg_addr == `ADCS_OFS_RES_LO && !result_valid |=> reg_rdata == res_q[7:0])
		else $error("result low byte wrong");
	a_rc_unimpl: assert property (
		reg_rd && reg_addr == `ADCS_OFS_RC_CTRL |=> reg_rdata[7:3] == 5'h00) else $error("rc high bits set");
	a_xt_unimpl: assert property (
		reg_rd && reg_addr == `ADCS_OFS_XT_CTRL |=> reg_rdata[7:4] == 4'h0) else $error("xt high bits set");
	a_pin_normal: assert property (
		!rc_out_q && !xt_out_q |=> data_ready_n_pin == $past(data_ready_n)) else $error("ready pin not normal");
	c_xt_on: cover property (wr_xt && reg_wdata[0]);
	c_rc_out: cover property (rc_out_q && $rose(data_ready_n_pin));
	c_xt_out: cover property (xt_out_q && $rose(data_ready_n_pin));
endmodule
bind adcs_top adcs_chk chk_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .result_data(result_data), .result_valid(result_valid),
	.data_ready_n(data_ready_n), .data_ready_n_pin(data_ready_n_pin), .rc_osc_enable(rc_osc_enable),
	.xtal_osc_enable(xtal_osc_enable), .xtal_drive_mode(xtal_drive_mode));

// ### verif/adcs_host.sv
// Host controller model driving the register port
`timescale 1ns/100ps
module adcs_host (
	input wire clk,
	output reg [4:0] reg_addr,
	output reg reg_wr,
	output reg reg_rd,
	output reg [7:0] reg_wdata,
	input wire [7:0] reg_rdata
);
	initial begin
		reg_addr = 5'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end
	task wr(input [4:0] a, input [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Read data is taken mid-cycle so it never races the edge that loads it
	task rd(input [4:0] a, output [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		v = reg_rdata;
	endtask
endmodule

// ### verif/testbench.sv
// Self-checking bench of the clock select block
`timescale 1ns/100ps
`include "adcs_defs.vh"
module testbench;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg [23:0] result_data = 24'h000000;
	reg result_valid = 1'b0;
	reg data_ready_n = 1'b1;
	reg rc_osc_clk = 1'b0;
	reg xtal_osc_clk = 1'b0;
	wire [4:0] reg_addr;
	wire reg_wr;
	wire reg_rd;
	wire [7:0] reg_wdata;
	wire [7:0] reg_rdata;
	wire data_ready_n_pin;
	wire [103:0] cfg_o;
	integer e0;
	integer n_fail = 0;
	integer checks = 0;
	integer ec [0:1];
	integer i;
	integer k;
	reg [7:0] d;
	reg [31:0] rows [0:19];
	always #2 clk = ~clk;
	always #12 rc_osc_clk = ~rc_osc_clk;
	always #20 xtal_osc_clk = ~xtal_osc_clk;
	always @(posedge rc_osc_clk) ec[0] = ec[0] + 1;
	always @(posedge xtal_osc_clk) ec[1] = ec[1] + 1;
	// Short crystal settle keeps the run brief
	adcs_top #(.XT_SETTLE(4)) dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .result_data(result_data), .result_valid(result_valid),
		.data_ready_n(data_ready_n), .rc_osc_clk(rc_osc_clk), .xtal_osc_clk(xtal_osc_clk),
		.data_ready_n_pin(data_ready_n_pin), .rc_osc_enable(), .xtal_osc_enable(), .xtal_drive_mode(),
		.input_pair_select(cfg_o[7:0]), .amplifier_gain_select(cfg_o[15:8]), .output_rate_config(cfg_o[23:16]),
		.analog_config_a(cfg_o[31:24]), .analog_config_b(cfg_o[39:32]), .analog_config_c(cfg_o[47:40]),
		.analog_config_d(cfg_o[55:48]), .analog_config_e(cfg_o[63:56]), .analog_config_f(cfg_o[71:64]),
		.analog_config_g(cfg_o[79:72]), .serial_iface_flag(cfg_o[87:80]), .serial_iface_control(cfg_o[95:88]),
		.serial_timeout_control(cfg_o[103:96]));
	adcs_host host_u (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata));
	task chk(input string nm, input [23:0] seen, input [23:0] exp);
		checks = checks + 1;
		if (seen !== exp) begin
			n_fail = n_fail + 1;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task print_verdict;
		if (n_fail == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task defaults;
		for (i = 0; i < 20; i = i + 1) begin
			host_u.rd(rows[i][28:24], d);
			chk("default", d, rows[i][23:16]);
			if (i < 13)
				chk("cfg_rst", cfg_o[i*8 +: 8], rows[i][23:16]);
		end
	endtask
	// Enable an oscillator and count its edges until the flag shows
	task settle(input [4:0] a, input [7:0] v, input integer s, input integer n);
		host_u.wr(a, v);
		ec[s] = 0;
		host_u.rd(a, d);
		chk("flag_early", d[1], 1'b0);
		k = 0;
		while (d[1] !== 1'b1 && k < 200) begin
			host_u.rd(a, d);
			k = k + 1;
		end
		chk("settle", ec[s] >= n - 1 && ec[s] <= n + 3, 1'b1);
	endtask
	task divide(input [4:0] a, input [7:0] v, input integer s);
		host_u.wr(a, v);
		repeat (2) @(posedge clk);
		k = 0;
		while (data_ready_n_pin !== 1'b1 && k < 40000) begin
			@(posedge clk);
			k = k + 1;
		end
		// Half period measured between two toggles, so the sync delay cancels
		e0 = ec[s];
		while (data_ready_n_pin !== 1'b0 && k < 80000) begin
			@(posedge clk);
			k = k + 1;
		end
		chk("divide", ec[s] - e0, `ADCS_CLK_DIV / 2);
	endtask
	initial begin
		ec[0] = 0;
		ec[1] = 0;
		rows[0] = 32'h00_00_A5_A5; rows[1] = 32'h01_00_5A_5A; rows[2] = 32'h02_01_FF_FF;
		rows[3] = 32'h03_01_4F_4F; rows[4] = 32'h04_26_20_20; rows[5] = 32'h05_20_A0_A0;
		rows[6] = 32'h06_07_8F_8F; rows[7] = 32'h07_01_4F_4F; rows[8] = 32'h08_14_10_10;
		rows[9] = 32'h0C_01_FE_00; rows[10] = 32'h0E_00_FF_01; rows[11] = 32'h0F_00_FF_3E;
		rows[12] = 32'h10_00_C3_C3; rows[13] = 32'h11_00_FA_00; rows[14] = 32'h12_00_F6_04;
		rows[15] = 32'h0D_00_FF_00; rows[16] = 32'h13_00_FF_00; rows[17] = 32'h09_00_FF_3C;
		rows[18] = 32'h0A_00_FF_C3; rows[19] = 32'h0B_00_FF_A5;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		defaults();
		@(posedge clk);
		result_data <= 24'hA5C33C;
		result_valid <= 1'b1;
		@(posedge clk);
		result_valid <= 1'b0;
		for (i = 0; i < 20; i = i + 1) begin
			host_u.wr(rows[i][28:24], rows[i][15:8]);
			host_u.rd(rows[i][28:24], d);
			chk("row", d, rows[i][7:0]);
			if (i < 13)
				chk("cfg", cfg_o[i*8 +: 8], rows[i][7:0]);
		end
		// Mode was set by the table before the crystal is enabled
		settle(`ADCS_OFS_XT_CTRL, 8'h05, 1, 4);
		host_u.wr(`ADCS_OFS_XT_CTRL, 8'h01);
		host_u.rd(`ADCS_OFS_XT_CTRL, d);
		chk("mode_hold", d, 8'h07);
		divide(`ADCS_OFS_XT_CTRL, 8'h0D, 1);
		host_u.wr(`ADCS_OFS_XT_CTRL, 8'h00);
		host_u.rd(`ADCS_OFS_XT_CTRL, d);
		chk("xt_off", d, 8'h04);
		settle(`ADCS_OFS_RC_CTRL, 8'h01, 0, 16);
		divide(`ADCS_OFS_RC_CTRL, 8'h05, 0);
		host_u.wr(`ADCS_OFS_RC_CTRL, 8'h01);
		data_ready_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk("pin", data_ready_n_pin, 1'b0);
		rst <= 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		defaults();
		print_verdict();
	end
	initial begin
		#400000;
		n_fail = n_fail + 1;
		print_verdict();
	end
endmodule
